// *** gdb_pkg.sv ***
// Package for the GPIO input sampling and de-bounce block.
// Assumes a single core clock domain and a simple register port.
package gdb_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] DEBOUNCE_EN_OFFSET = 12'h638;
  localparam logic [11:0] LOW_INPUT_OFFSET   = 12'h63C;
  localparam logic [31:0] DEBOUNCE_EN_RESET  = 32'h0000_0000;
  localparam logic [15:0] RESERVED_READ      = 16'h0000;

  // ************************************************************
  // Geometry and timing
  // ************************************************************
  localparam int          PIN_COUNT        = 32;
  localparam int          LOW_PIN_COUNT    = 16;
  localparam int          FILTER_CNT_W     = 8;
  // Consecutive core-clock samples a new level must hold
  localparam int          FILTER_SAMPLES   = 4;
  localparam logic [31:0] PIN_RESET        = 32'h0000_0000;

  // ************************************************************
  // Register port request
  // ************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } gdb_cfg_req_t;

endpackage

// *** gdb_filter.sv ***
// One-pin de-bounce filter.
// Assumes level_in is already synchronised to core_clk_in.
`timescale 1ns/1ps
`default_nettype none

module gdb_filter #(
  parameter int SAMPLES = gdb_pkg::FILTER_SAMPLES
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  input  wire logic level_in,
  output var  logic level_out
);

  // ************************************************************
  // Filter state
  // ************************************************************
  localparam logic [gdb_pkg::FILTER_CNT_W-1:0] LAST_COUNT =
    gdb_pkg::FILTER_CNT_W'(SAMPLES - 1);

  logic [gdb_pkg::FILTER_CNT_W-1:0] count;

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !enable_in || level_in == level_out) begin
      count <= '0;
    end else if (count != LAST_COUNT) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (!enable_in) begin
      level_out <= level_in;   // Tracks raw so enabling does not glitch
    end else if (level_in != level_out && count == LAST_COUNT) begin
      level_out <= level_in;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_filter_change: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (enable_in && level_in != level_out && count == LAST_COUNT)
      |=> level_out == $past(level_in))
    else $error("filter did not take a level held long enough");

  a_filter_holds: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (enable_in && count != LAST_COUNT) |=> $stable(level_out))
    else $error("filter changed before the level was held long enough");

  a_bypass_raw: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !enable_in |=> level_out == $past(level_in))
    else $error("unfiltered pin did not follow raw level");

endmodule

`default_nettype wire

// *** gdb_top.sv ***
// Input sampling and de-bounce for 32 GPIO pins; input data read-back for pins 0 to 15.
// Assumes pins are asynchronous; direction bits come from core-clock logic.
//
// Summary of operation
// - 32-bit de-bounce enable, one bit per pin
// - Enabled input pins pass through de-bounce filter
// - Disabled bits use raw level; enables reset zero
// - Low input data bit zero when pin output
// - Input pin bit returns current sampled level
// - Upper sixteen bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module gdb_top (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire logic [31:0]           pin_level_in,
  input  wire logic [31:0]           dir_low_in,
  input  wire logic [31:0]           dir_high_in,
  input  wire gdb_pkg::gdb_cfg_req_t cfg_req_in,
  output var  logic [31:0]           cfg_rdata_out,
  output var  logic                  cfg_rvalid_out,
  output var  logic [31:0]           pin_value_out,
  output var  logic [31:0]           debounce_en_out
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0] sync_meta;
  logic [31:0] sync_level;
  logic [31:0] pin_is_output;
  logic [31:0] filter_en;
  logic [15:0] low_out_mask;
  logic [15:0] next_low_input;
  logic        wr_debounce;
  logic        rd_debounce;
  logic        rd_low_input;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  // Two-stage synchroniser; first stage feeds only the second
  // Second stage output is what every later stage reads
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_meta  <= gdb_pkg::PIN_RESET;
      sync_level <= gdb_pkg::PIN_RESET;
    end else begin
      sync_meta  <= pin_level_in;
      sync_level <= sync_meta;
    end
  end

  // ************************************************************
  // Direction decode
  // ************************************************************

  // Direction bit of pin n sits at bit 2n+1 of its register
  // The even bits pick source or destination and are not used here
  always_comb begin
    pin_is_output = '0;
    for (int n = 0; n < gdb_pkg::LOW_PIN_COUNT; n++) begin
      pin_is_output[n]      = dir_low_in[2*n+1];
      pin_is_output[n + 16] = dir_high_in[2*n+1];
    end
  end

  assign low_out_mask = pin_is_output[15:0];

  // ************************************************************
  // Register decode
  // ************************************************************
  // Exact address match; writes to the input data register are dropped
  assign wr_debounce  = cfg_req_in.wr && cfg_req_in.addr == gdb_pkg::DEBOUNCE_EN_OFFSET;
  assign rd_debounce  = cfg_req_in.rd && cfg_req_in.addr == gdb_pkg::DEBOUNCE_EN_OFFSET;
  assign rd_low_input = cfg_req_in.rd && cfg_req_in.addr == gdb_pkg::LOW_INPUT_OFFSET;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      debounce_en_out <= gdb_pkg::DEBOUNCE_EN_RESET;
    end else if (wr_debounce) begin
      debounce_en_out <= cfg_req_in.wdata;
    end
  end

  // ************************************************************
  // De-bounce filters
  // ************************************************************

  assign filter_en = debounce_en_out & ~pin_is_output;

  // One filter per pin; a disabled filter tracks the raw level
  for (genvar g = 0; g < gdb_pkg::PIN_COUNT; g++) begin : g_pin
    gdb_filter #(
      .SAMPLES (gdb_pkg::FILTER_SAMPLES)
    ) u_filter (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .enable_in   (filter_en[g]),
      .level_in    (sync_level[g]),
      .level_out   (pin_value_out[g])
    );
  end

  // ************************************************************
  // Read-back
  // ************************************************************

  assign next_low_input = pin_value_out[15:0] & ~low_out_mask;

  // Read data is registered; unmapped addresses read zero
  // A read and a write in one cycle return the old enable bits
  // reserved bits read zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_rdata_out  <= '0;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_req_in.rd;
      if (rd_debounce) begin
        cfg_rdata_out <= debounce_en_out;
      end else if (rd_low_input) begin
        cfg_rdata_out <= {gdb_pkg::RESERVED_READ, next_low_input};
      end else begin
        cfg_rdata_out <= '0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_enable_reset: assert property (
    @(posedge core_clk_in)
    rst_in |=> debounce_en_out == gdb_pkg::DEBOUNCE_EN_RESET)
    else $error("de-bounce enables not zero after reset");

  a_enable_write: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    wr_debounce |=> debounce_en_out == $past(cfg_req_in.wdata))
    else $error("de-bounce enable write not stored");

  a_output_zero: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    rd_low_input |=> (cfg_rdata_out[15:0] & $past(low_out_mask)) == 16'h0000)
    else $error("output pin read back nonzero");

  a_input_level: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (rd_low_input && low_out_mask == 16'h0000)
      |=> cfg_rdata_out[15:0] == $past(pin_value_out[15:0]) && cfg_rvalid_out)
    else $error("input pin level not returned");

  a_reserved_zero: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    rd_low_input |=> cfg_rdata_out[31:16] == 16'h0000)
    else $error("reserved input data bits nonzero");

  a_enable_read: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    rd_debounce |=> cfg_rdata_out == $past(debounce_en_out))
    else $error("de-bounce enable read back wrong");

  a_enable_hold: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !wr_debounce |=> $stable(debounce_en_out))
    else $error("de-bounce enables changed without a write");

  a_write_ignored: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (cfg_req_in.wr && cfg_req_in.addr == gdb_pkg::LOW_INPUT_OFFSET)
      |=> $stable(debounce_en_out))
    else $error("write to input data register had an effect");

  a_read_valid: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    cfg_req_in.rd |=> cfg_rvalid_out)
    else $error("read not answered one cycle later");

  a_no_stray_valid: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !cfg_req_in.rd |=> !cfg_rvalid_out)
    else $error("read valid without a read");

  a_unmapped_zero: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (cfg_req_in.rd && !rd_debounce && !rd_low_input) |=> cfg_rdata_out == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  a_rdata_idle: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !cfg_req_in.rd |=> cfg_rdata_out == 32'h0000_0000)
    else $error("read data nonzero without a read");

  a_sync_chain: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> sync_level == $past(sync_meta))
    else $error("pin synchroniser stage skipped");

  for (genvar p = 0; p < gdb_pkg::PIN_COUNT; p++) begin : g_chk
    a_output_unfiltered: assert property (
      @(posedge core_clk_in) disable iff (rst_in)
      pin_is_output[p] |=> pin_value_out[p] == $past(sync_level[p]))
      else $error("output pin level was filtered");
  end

endmodule

`default_nettype wire

// *** gdb_pin_model.sv ***
// Model of the external signals on the general-purpose pins.
// Assumes the bench sets levels at falling edges; pins bounce only on command.
`timescale 1ns/1ps
`default_nettype none

module gdb_pin_model (
  input  wire logic        core_clk_in,
  input  wire logic [31:0] level_in,
  input  wire logic [31:0] bounce_in,
  output var  logic [31:0] pin_level_out
);
  logic phase = 1'b0;

  // Bouncing pins flip at every falling edge, never settling for two samples
  always @(negedge core_clk_in) begin
    phase <= ~phase;
  end

  // Steady pins show the commanded level
  assign pin_level_out = level_in ^ (bounce_in & {32{phase}});
endmodule

`default_nettype wire

// *** gdb_top_test.sv ***
// Self-checking bench for the pin sampling and de-bounce block.
// Assumes the pin model on the far side and the registered read port.
`timescale 1ns/1ps
`default_nettype none

module gdb_top_test;
  logic                  core_clk_in = 1'b0;
  logic                  rst_in      = 1'b1;
  logic [31:0]           lvl         = 32'h0000_0000;
  logic [31:0]           bnc         = 32'h0000_0000;
  logic [31:0]           dir_lo      = 32'h0000_0000;
  logic [31:0]           dir_hi      = 32'h0000_0000;
  logic [31:0]           pins;
  logic [31:0]           rdata;
  logic [31:0]           pv;
  logic [31:0]           en_out;
  logic [31:0]           q;
  logic                  rv;
  gdb_pkg::gdb_cfg_req_t req         = '0;
  int                    fail_count  = 0;
  int                    n_compared  = 0;

  // ************************************************************
  // Clock, far side and design
  // ************************************************************
  always #50 core_clk_in = ~core_clk_in;

  gdb_pin_model u_pins (.core_clk_in(core_clk_in), .level_in(lvl), .bounce_in(bnc),
    .pin_level_out(pins));
  gdb_top u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .pin_level_in(pins),
    .dir_low_in(dir_lo), .dir_high_in(dir_hi), .cfg_req_in(req), .cfg_rdata_out(rdata),
    .cfg_rvalid_out(rv), .pin_value_out(pv), .debounce_en_out(en_out));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // One register access; read data taken while the valid pulse stands,
  // then an idle edge so the next request starts from a released port
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d);
    req = '{addr: a, wr: w, rd: ~w, wdata: d};
    cyc(1);
    check({31'h0, rv}, {31'h0, ~w});
    q = rdata;
    req = '0;
    cyc(1);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    acc(12'h638, 1'b0, 32'h0);
    check(q, 32'h0000_0000);
    acc(12'h638, 1'b1, 32'hA5A5_F00F);
    check(en_out, 32'hA5A5_F00F);
    acc(12'h63C, 1'b1, 32'hFFFF_FFFF);
    acc(12'h638, 1'b0, 32'h0);
    check(q, 32'hA5A5_F00F);
    acc(12'h700, 1'b0, 32'h0);
    check(q, 32'h0000_0000);
    acc(12'h638, 1'b1, 32'h0);
  endtask

  task automatic t_raw();
    lvl = 32'hFFFF_1237;
    dir_lo = 32'h0000_000A;
    cyc(2);
    check(pv, 32'h0000_0000);
    cyc(1);
    check(pv, 32'hFFFF_1237);
    acc(12'h63C, 1'b0, 32'h0);
    check(q, 32'h0000_1234);
    lvl = 32'h0000_0000;
    dir_lo = 32'h0000_0000;
    cyc(6);
  endtask

  task automatic t_filter();
    acc(12'h638, 1'b1, 32'h0000_0001);
    lvl = 32'h0000_0001;
    cyc(3);
    lvl = 32'h0000_0000;
    cyc(8);
    check(pv, 32'h0000_0000);
    bnc = 32'h0000_0001;
    cyc(12);
    check(pv, 32'h0000_0000);
    bnc = 32'h0000_0000;
    cyc(3);
    lvl = 32'h0000_0001;
    cyc(5);
    check(pv, 32'h0000_0000);
    cyc(1);
    check(pv, 32'h0000_0001);
    acc(12'h63C, 1'b0, 32'h0);
    check(q, 32'h0000_0001);
    dir_lo = 32'h0000_0002;
    dir_hi = 32'h0000_0002;
    acc(12'h638, 1'b1, 32'h0001_0001);
    lvl = 32'h0001_0000;
    cyc(3);
    check(pv, 32'h0001_0000);
  endtask

  // Main sequence: reset, then every scenario in turn
  initial begin
    cyc(2);
    rst_in = 1'b0;
    t_regs();
    t_raw();
    t_filter();
    give_verdict();
  end

  // Watchdog cuts a hang short
  initial begin
    cyc(2000);
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
